// File: hdl/compare_output_unit.sv
`timescale 1ns/100ps

// Waveform output state for one compare channel.
module compare_output_unit
  import tc_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic tick,
  input wire wave_mode_t mode,
  input wire logic [1:0] out_mode,
  input wire logic toggle_ok,
  input wire logic [7:0] cmp,
  input wire logic [7:0] count,
  input wire logic count_up,
  input wire logic [7:0] top,
  output logic match,
  output logic wave
);
`include "tc_consts.svh"

  logic wave_q;  // Output state register.
  logic at_top;  // Counter sits at TOP on this tick.
  logic cmp_top; // Compare value equals TOP.

  assign match = tick && (count == cmp);
  assign at_top = tick && (count == top);
  assign cmp_top = (cmp == top);
  assign wave = wave_q;

  // --------------------------------------------------------------------
  // Output actions on compare match, BOTTOM and TOP.
  // --------------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      wave_q <= 1'b0;
    else if (out_mode == 2'b01)
    begin
      // Toggle: always outside PWM, in PWM only when allowed.
      if (match && (toggle_ok || !(is_fast(mode) || is_phase(mode))))
        wave_q <= ~wave_q;
    end
    else if (out_mode[1])
    begin
      if (is_fast(mode))
      begin
        // Wrap to BOTTOM wins; match at TOP is ignored.
        if (at_top)
          wave_q <= ~out_mode[0];
        else if (match && !cmp_top)
          wave_q <= out_mode[0];
      end
      else if (is_phase(mode))
      begin
        // Compare at TOP: only the TOP action is done.
        if (at_top && cmp_top)
          wave_q <= ~out_mode[0];
        else if (match)
          wave_q <= count_up ? out_mode[0] : ~out_mode[0];
      end
      else if (match)
        wave_q <= out_mode[0];
    end
  end

endmodule

// File: hdl/counter_link_if.sv
`timescale 1ns/100ps

// Links the control logic to the counter core.
interface counter_link_if;
  logic tick;             // Timer tick, a one-cycle enable.
  tc_pkg::wave_mode_t mode; // Selected waveform mode.
  logic [7:0] cmp_a;      // Compare A value, TOP in some modes.
  logic load;             // Software write to the counter.
  logic [7:0] load_value; // Value written to the counter.
  logic [7:0] count;      // Present counter value.
  logic count_up;         // High while counting upward.

  modport counter (input tick, mode, cmp_a, load, load_value,
                   output count, count_up);
  modport user (output tick, mode, cmp_a, load, load_value,
                input count, count_up);
endinterface

// File: hdl/tc_consts.svh
`ifndef TC_CONSTS_SVH
`define TC_CONSTS_SVH

// ----------------------------------------------------------------------
// Register byte offsets on the register bus.
// ----------------------------------------------------------------------
`define OFS_CTRL 8'h44
`define OFS_MODE_EXT 8'h48
`define OFS_CMP_A 8'h4c
`define OFS_CMP_B 8'h50
`define OFS_COUNT 8'h54
`define OFS_FLAGS 8'h58
`define OFS_PIN_DIR 8'h5c

// ----------------------------------------------------------------------
// Field positions in the control register and helper registers.
// ----------------------------------------------------------------------
`define CTRL_A_MODE_HI 7
`define CTRL_A_MODE_LO 6
`define CTRL_B_MODE_HI 5
`define CTRL_B_MODE_LO 4
`define CTRL_WAVE_BIT1 1
`define CTRL_WAVE_BIT0 0
`define CTRL_RW_MASK 8'hf3
`define FLAG_A_BIT 0
`define FLAG_B_BIT 1

// ----------------------------------------------------------------------
// Reset values and counter limits.
// ----------------------------------------------------------------------
`define CTRL_RESET 8'h00
`define COUNT_BOTTOM 8'h00
`define COUNT_MAX 8'hff

`endif

// File: hdl/tc_pkg.sv
package tc_pkg;

  // --------------------------------------------------------------------
  // Waveform generation modes, as the three mode-select bits.
  // --------------------------------------------------------------------
  typedef enum logic [2:0] {
    WM_NORMAL = 3'b000,
    WM_PHASE_MAX = 3'b001,
    WM_CLEAR_ON_MATCH = 3'b010,
    WM_FAST_MAX = 3'b011,
    WM_RSV_4 = 3'b100,
    WM_PHASE_CMP = 3'b101,
    WM_RSV_6 = 3'b110,
    WM_FAST_CMP = 3'b111
  } wave_mode_t;

  // True for both fast PWM modes.
  function automatic logic is_fast(input wave_mode_t m);
    is_fast = (m == WM_FAST_MAX) || (m == WM_FAST_CMP);
  endfunction

  // True for both phase-correct PWM modes.
  function automatic logic is_phase(input wave_mode_t m);
    is_phase = (m == WM_PHASE_MAX) || (m == WM_PHASE_CMP);
  endfunction

  // Counter TOP: compare A in clear-on-match and the compare-A PWM modes.
  function automatic logic [7:0] mode_top(input wave_mode_t m,
                                          input logic [7:0] cmp_a);
    if ((m == WM_CLEAR_ON_MATCH) || (m == WM_PHASE_CMP) ||
        (m == WM_FAST_CMP))
      mode_top = cmp_a;
    else
      mode_top = 8'hff;
  endfunction

endpackage

// File: hdl/timer_compare_output_control.sv
`timescale 1ns/100ps

// Contract
// - Synchronous to clk; tick only enables counting.
// - Nonzero A mode replaces A pin function, except mode 01 in PWM without bit2.
// - Pin driver enabled only by direction bit.
// - A non-PWM: off, toggle, clear, set.
// - PWM A mode 01 toggles only if bit2.
// - Fast A 10: clear on match, set BOTTOM.
// - Fast A 11: set on match, clear BOTTOM.
// - Fast A compare at TOP: only BOTTOM action.
// - Phase A 10: clear up, set down.
// - Phase A 11: set up, clear down.
// - Phase A compare at TOP: act at TOP.
// - Nonzero B mode replaces B pin function.
// - B non-PWM: off, toggle, clear, set.
// - Fast B 10/11: match and BOTTOM actions.
// - Phase B 10/11: up and down actions.
// - B compare at TOP: ignore match, act TOP.
// - Compare-A TOP sets A flag, clears counter; in phase compare-A mode the counter turns down instead.
// - Mode bits select sequence and TOP source.
// - Phase mode counts up then down.
module timer_compare_output_control
  import tc_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic timer_tick_enable,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic port_a_data,
  input wire logic port_b_data,
  output logic chan_a_pin_out,
  output logic chan_a_pin_oe_n,
  output logic chan_b_pin_out,
  output logic chan_b_pin_oe_n,
  output logic chan_a_match_flag,
  output logic chan_b_match_flag
);
`include "tc_consts.svh"

  // ----------------------------------------------------------------------
  // Registers and internal signals
  // ----------------------------------------------------------------------

  // Control register: both output modes and the two low mode bits.
  logic [7:0] ctrl_q;
  // Third mode-select bit.
  logic wave_mode_bit2_q;
  // Compare values for both channels.
  logic [7:0] chan_a_compare_value_q;
  logic [7:0] chan_b_compare_value_q;
  // Pin direction bits, high for output.
  logic [1:0] pin_dir_q;
  // Sticky match flags.
  logic flag_a_q;
  logic flag_b_q;
  // Bus answer registers.
  logic wait_q;
  logic [31:0] rdata_q;
  // Registered pin drive.
  logic pin_a_q;
  logic pin_b_q;
  logic oe_a_n_q;
  logic oe_b_n_q;

  // Output mode fields, decoded from the control register.
  logic [1:0] chan_a_output_mode;
  logic [1:0] chan_b_output_mode;
  // Selected waveform mode.
  wave_mode_t mode;
  // TOP value for the selected mode.
  logic [7:0] top;
  // Bus write accepted this cycle on the low byte lane.
  logic wr_go;
  // Channel A waveform owns its pin; a PWM toggle needs the third bit.
  logic chan_a_connected;
  // Match events and wave states from the channel units.
  logic match_a;
  logic match_b;
  logic chan_a_wave_out;
  logic chan_b_wave_out;

  // Link to the counter core.
  counter_link_if link ();

  assign chan_a_output_mode = ctrl_q[`CTRL_A_MODE_HI:`CTRL_A_MODE_LO];
  assign chan_b_output_mode = ctrl_q[`CTRL_B_MODE_HI:`CTRL_B_MODE_LO];
  assign mode = wave_mode_t'({wave_mode_bit2_q,
                              ctrl_q[`CTRL_WAVE_BIT1],
                              ctrl_q[`CTRL_WAVE_BIT0]});
  assign top = mode_top(mode, chan_a_compare_value_q);
  assign wr_go = avs_write && !wait_q && avs_byteenable[0];
  // Mode 01 in PWM without the third bit leaves the pin to the port.
  assign chan_a_connected = (chan_a_output_mode != 2'b00) &&
    !((chan_a_output_mode == 2'b01) && !wave_mode_bit2_q &&
      (is_fast(mode) || is_phase(mode)));

  // ----------------------------------------------------------------------
  // Counter core
  // ----------------------------------------------------------------------

  // The tick is a same-clock enable; no crossing is needed.
  assign link.tick = timer_tick_enable;
  assign link.mode = mode;
  assign link.cmp_a = chan_a_compare_value_q;
  assign link.load = wr_go && (avs_address == `OFS_COUNT);
  assign link.load_value = avs_writedata[7:0];

  // Counter with both slope sequences.
  wave_counter counter_core (
    .clk(clk),
    .reset_n(reset_n),
    .link(link.counter)
  );

  // ----------------------------------------------------------------------
  // Compare channels
  // ----------------------------------------------------------------------

  // Channel A may toggle in PWM when the third mode bit is set.
  compare_output_unit unit_a (
    .clk(clk),
    .reset_n(reset_n),
    .tick(timer_tick_enable),
    .mode(mode),
    .out_mode(chan_a_output_mode),
    .toggle_ok(wave_mode_bit2_q),
    .cmp(chan_a_compare_value_q),
    .count(link.count),
    .count_up(link.count_up),
    .top(top),
    .match(match_a),
    .wave(chan_a_wave_out)
  );

  // Channel B has no toggle in PWM; mode 01 leaves it untouched.
  compare_output_unit unit_b (
    .clk(clk),
    .reset_n(reset_n),
    .tick(timer_tick_enable),
    .mode(mode),
    .out_mode(chan_b_output_mode),
    .toggle_ok(1'b0),
    .cmp(chan_b_compare_value_q),
    .count(link.count),
    .count_up(link.count_up),
    .top(top),
    .match(match_b),
    .wave(chan_b_wave_out)
  );

  // ----------------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------------

  // A nonzero output mode takes the pin from the port logic, except channel A
  // mode 01 in PWM without the third bit. The driver follows only the
  // direction bit, even while overridden.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pin_a_q <= 1'b0;
      pin_b_q <= 1'b0;
      oe_a_n_q <= 1'b1;
      oe_b_n_q <= 1'b1;
    end
    else
    begin
      pin_a_q <= chan_a_connected ?
                 chan_a_wave_out : port_a_data;
      pin_b_q <= (chan_b_output_mode != 2'b00) ?
                 chan_b_wave_out : port_b_data;
      oe_a_n_q <= ~pin_dir_q[0];
      oe_b_n_q <= ~pin_dir_q[1];
    end
  end

  // ----------------------------------------------------------------------
  // Match flags
  // ----------------------------------------------------------------------

  // Flags are sticky; writing a one clears, and a match in the same
  // cycle wins over the clear.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      flag_a_q <= 1'b0;
      flag_b_q <= 1'b0;
    end
    else
    begin
      if (match_a)
        flag_a_q <= 1'b1;
      else if (wr_go && (avs_address == `OFS_FLAGS) &&
               avs_writedata[`FLAG_A_BIT])
        flag_a_q <= 1'b0;
      if (match_b)
        flag_b_q <= 1'b1;
      else if (wr_go && (avs_address == `OFS_FLAGS) &&
               avs_writedata[`FLAG_B_BIT])
        flag_b_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------------

  // Writes take effect at the edge where waitrequest is low.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ctrl_q <= `CTRL_RESET;
      wave_mode_bit2_q <= 1'b0;
      chan_a_compare_value_q <= 8'h00;
      chan_b_compare_value_q <= 8'h00;
      pin_dir_q <= 2'b00;
    end
    else if (wr_go)
    begin
      unique case (avs_address)
        `OFS_CTRL:
          ctrl_q <= avs_writedata[7:0] & `CTRL_RW_MASK;
        `OFS_MODE_EXT:
          wave_mode_bit2_q <= avs_writedata[0];
        `OFS_CMP_A:
          chan_a_compare_value_q <= avs_writedata[7:0];
        `OFS_CMP_B:
          chan_b_compare_value_q <= avs_writedata[7:0];
        `OFS_PIN_DIR:
          pin_dir_q <= avs_writedata[1:0];
        default:
          // Counter and flags are handled elsewhere; unmapped ignored.
          pin_dir_q <= pin_dir_q;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Bus answer
  // ----------------------------------------------------------------------

  // Waitrequest drops for one cycle after a request is seen, then
  // rises again; read data are captured for that cycle.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wait_q <= 1'b1;
      rdata_q <= 32'h00000000;
    end
    else if ((avs_read || avs_write) && wait_q)
    begin
      wait_q <= 1'b0;
      rdata_q <= 32'h00000000;
      if (avs_read)
      begin
        unique case (avs_address)
          `OFS_CTRL:
            rdata_q[7:0] <= ctrl_q;
          `OFS_MODE_EXT:
            rdata_q[0] <= wave_mode_bit2_q;
          `OFS_CMP_A:
            rdata_q[7:0] <= chan_a_compare_value_q;
          `OFS_CMP_B:
            rdata_q[7:0] <= chan_b_compare_value_q;
          `OFS_COUNT:
            rdata_q[7:0] <= link.count;
          `OFS_FLAGS:
            rdata_q[1:0] <= {flag_b_q, flag_a_q};
          `OFS_PIN_DIR:
            rdata_q[1:0] <= pin_dir_q;
          default:
            // Unmapped addresses read as zero.
            rdata_q <= 32'h00000000;
        endcase
      end
    end
    else
      wait_q <= 1'b1;
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------

  assign avs_readdata = rdata_q;
  assign avs_waitrequest = wait_q;
  assign chan_a_pin_out = pin_a_q;
  assign chan_b_pin_out = pin_b_q;
  assign chan_a_pin_oe_n = oe_a_n_q;
  assign chan_b_pin_oe_n = oe_b_n_q;
  assign chan_a_match_flag = flag_a_q;
  assign chan_b_match_flag = flag_b_q;

endmodule

// File: hdl/wave_counter.sv
`timescale 1ns/100ps

// 8-bit counter core with single- and dual-slope sequences.
module wave_counter
  import tc_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  counter_link_if.counter link
);
`include "tc_consts.svh"

  logic [7:0] count_q; // Counter value.
  logic up_q;          // Count direction, high for upward.
  logic [7:0] top;     // TOP for the selected mode.

  assign top = mode_top(link.mode, link.cmp_a);
  assign link.count = count_q;
  assign link.count_up = up_q;

  // --------------------------------------------------------------------
  // Counting, advanced only on a timer tick.
  // --------------------------------------------------------------------
  // The core runs on clk; the tick is only an enable.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      count_q <= `COUNT_BOTTOM;
      up_q <= 1'b1;
    end
    else if (link.load)
    begin
      // A software write takes the counter directly.
      count_q <= link.load_value;
    end
    else if (link.tick)
    begin
      if (is_phase(link.mode))
      begin
        // Dual slope: up to TOP, then down to BOTTOM.
        if (up_q)
        begin
          if ((count_q >= top) && (top != `COUNT_BOTTOM))
          begin
            count_q <= count_q - 8'h01;
            up_q <= 1'b0;
          end
          else
            count_q <= count_q + 8'h01;
        end
        else if (count_q == `COUNT_BOTTOM)
        begin
          count_q <= count_q + 8'h01;
          up_q <= 1'b1;
        end
        else
          count_q <= count_q - 8'h01;
      end
      else
      begin
        // Single slope: cleared on the tick after TOP.
        up_q <= 1'b1;
        if (count_q == top)
          count_q <= `COUNT_BOTTOM;
        else
          count_q <= count_q + 8'h01;
      end
    end
  end

endmodule

// File: tb/pin_pad_model.sv
`timescale 1ns/100ps

// ------------------------------------------
// Port pad as seen from outside the device.
// ------------------------------------------
module pin_pad_model
(
  input wire logic pin_out,
  input wire logic pin_oe_n,
  output logic pad
);
  logic last_q; // Level last driven onto the pad.

  // The pad carries the pin only while the driver is on; a floating pad
  // shows the inverse of its last level so stale values never pass.
  always @(pin_out or pin_oe_n)
  begin
    if (!pin_oe_n)
    begin
      pad = pin_out;
      last_q = pin_out;
    end
    else
    begin
      pad = ~last_q;
    end
  end
endmodule

// File: tb/timer_compare_output_control_monitor.sv
`timescale 1ns/100ps
`include "tc_consts.svh"

// ------------------------------------------
// Port checker for the compare output block.
// ------------------------------------------
module timer_compare_output_control_monitor
  import tc_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic timer_tick_enable,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic port_a_data,
  input wire logic port_b_data,
  input wire logic chan_a_pin_out,
  input wire logic chan_a_pin_oe_n,
  input wire logic chan_b_pin_out,
  input wire logic chan_b_pin_oe_n,
  input wire logic chan_a_match_flag,
  input wire logic chan_b_match_flag
);
  logic [7:0] ctrl_q; // Control value as software last wrote it.
  logic [1:0] dir_q; // Pin direction bits as last written.
  logic ext_q; // Third mode bit as last written.
  logic wr_done; // A byte-enabled write completes at this edge.

  assign wr_done = avs_write && !avs_waitrequest && avs_byteenable[0];

  // Mirrors the control and direction registers from bus writes.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ctrl_q <= 8'h00;
      dir_q <= 2'h0;
      ext_q <= 1'b0;
    end
    else if (wr_done && avs_address == `OFS_CTRL)
    begin
      ctrl_q <= avs_writedata[7:0] & `CTRL_RW_MASK;
    end
    else if (wr_done && avs_address == `OFS_PIN_DIR)
    begin
      dir_q <= avs_writedata[1:0];
    end
    else if (wr_done && avs_address == `OFS_MODE_EXT)
    begin
      ext_q <= avs_writedata[0];
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  // A request is seen, then answered for exactly one cycle.
  sequence s_req;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_answer;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence

  property p_bus_answer;
    s_req |=> s_answer;
  endproperty
  a_bus_answer: assert property (p_bus_answer)
    else $error("bus answer not one cycle after request");

  property p_ctrl_read;
    avs_read && !avs_waitrequest && avs_address == `OFS_CTRL
      |-> avs_readdata == {24'h000000, ctrl_q};
  endproperty
  a_ctrl_read: assert property (p_ctrl_read)
    else $error("control register read back wrong");

  property p_dir_oe;
    $stable(dir_q) |-> {chan_b_pin_oe_n, chan_a_pin_oe_n} == ~dir_q;
  endproperty
  a_dir_oe: assert property (p_dir_oe)
    else $error("pin driver enable differs from direction");

  property p_port_a;
    $past(reset_n) && ctrl_q[7:6] == 2'b00 && $stable(ctrl_q)
      |-> chan_a_pin_out == $past(port_a_data);
  endproperty
  a_port_a: assert property (p_port_a)
    else $error("pin a not following port data");

  property p_port_b;
    $past(reset_n) && ctrl_q[5:4] == 2'b00 && $stable(ctrl_q)
      |-> chan_b_pin_out == $past(port_b_data);
  endproperty
  a_port_b: assert property (p_port_b)
    else $error("pin b not following port data");

  property p_reset_low;
    $rose(reset_n) |-> !chan_a_pin_out && !chan_b_pin_out
      && chan_a_pin_oe_n && chan_b_pin_oe_n;
  endproperty
  a_reset_low: assert property (p_reset_low)
    else $error("pins not idle after reset");

  property p_tick_hold_a;
    !$past(timer_tick_enable, 2) && $past(ctrl_q) == $past(ctrl_q, 2)
      && $past(ext_q) == $past(ext_q, 2)
      && $past(ctrl_q[7:6]) != 2'b00 |-> $stable(chan_a_pin_out);
  endproperty
  a_tick_hold_a: assert property (p_tick_hold_a)
    else $error("wave a moved without a tick");

  property p_flag_tick;
    $rose(chan_a_match_flag) || $rose(chan_b_match_flag)
      |-> $past(timer_tick_enable);
  endproperty
  a_flag_tick: assert property (p_flag_tick)
    else $error("match flag set without a tick");
endmodule

bind timer_compare_output_control timer_compare_output_control_monitor
  monitor (.clk, .reset_n, .timer_tick_enable, .avs_address, .avs_read,
  .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
  .avs_waitrequest, .port_a_data, .port_b_data, .chan_a_pin_out,
  .chan_a_pin_oe_n, .chan_b_pin_out, .chan_b_pin_oe_n,
  .chan_a_match_flag, .chan_b_match_flag);

// File: tb/timer_compare_output_control_test.sv
`timescale 1ns/100ps
`include "tc_consts.svh"

// ------------------------------------------
// Self-checking bench for the compare output block.
// ------------------------------------------
module timer_compare_output_control_test
  import tc_pkg::*;
;
  logic clk = 1'b0; // Block clock.
  logic reset_n = 1'b0; // Held low for the first cycles.
  logic timer_tick_enable = 1'b0; // Counting enable.
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic port_a_data = 1'b0; // Normal port values.
  logic port_b_data = 1'b0;
  logic chan_a_pin_out, chan_a_pin_oe_n, chan_b_pin_out, chan_b_pin_oe_n;
  logic chan_a_match_flag, chan_b_match_flag;
  logic pad_a, pad_b; // Pad levels from the pad models.
  logic [31:0] rd; // Data of the last read.
  int mismatches = 0;
  int num_checks = 0;

  always #5 clk = ~clk;

  timer_compare_output_control dut (.clk, .reset_n, .timer_tick_enable,
    .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
    .avs_readdata, .avs_waitrequest, .port_a_data, .port_b_data,
    .chan_a_pin_out, .chan_a_pin_oe_n, .chan_b_pin_out, .chan_b_pin_oe_n,
    .chan_a_match_flag, .chan_b_match_flag);
  pin_pad_model pad_a_model (.pin_out(chan_a_pin_out),
    .pin_oe_n(chan_a_pin_oe_n), .pad(pad_a));
  pin_pad_model pad_b_model (.pin_out(chan_b_pin_out),
    .pin_oe_n(chan_b_pin_oe_n), .pad(pad_b));

  // Prints the verdict and ends the run.
  task automatic tally_and_finish();
    if (mismatches == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Compares one result against its expected value.
  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  // One bus access, held until waitrequest is sampled low.
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 40);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (avs_waitrequest !== 1'b0)
    begin
      mismatches++;
      tally_and_finish();
    end
  endtask

  // Reads a register and compares it.
  task automatic rd_check(input string what, input logic [7:0] a,
                          input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(what, exp, rd);
  endtask

  // Sets mode, compares and count, gives n ticks, then checks the pads.
  task automatic run_case(input logic [7:0] ctl, input logic ext,
                          input logic [7:0] ca, cb, cnt, input int n,
                          input logic ea, eb);
    bus(1'b1, `OFS_CTRL, {24'h0, ctl});
    bus(1'b1, `OFS_MODE_EXT, {31'h0, ext});
    bus(1'b1, `OFS_CMP_A, {24'h0, ca});
    bus(1'b1, `OFS_CMP_B, {24'h0, cb});
    bus(1'b1, `OFS_COUNT, {24'h0, cnt});
    repeat (n)
    begin
      @(posedge clk);
      timer_tick_enable <= 1'b1;
    end
    @(posedge clk);
    timer_tick_enable <= 1'b0;
    @(posedge clk);
    #1;
    check("pads", {30'h0, eb, ea}, {30'h0, pad_b, pad_a});
  endtask

  // Waits two edges so registered pin outputs settle.
  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask

  // Main sequence.
  initial
  begin
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    #1;
    check("pins", 32'hc, {28'h0, chan_b_pin_oe_n, chan_a_pin_oe_n,
          chan_b_pin_out, chan_a_pin_out});
    rd_check("ctrl reset", `OFS_CTRL, 32'h0);
    rd_check("unmapped", 8'h40, 32'h0);
    avs_byteenable <= 4'h0;
    bus(1'b1, `OFS_CTRL, 32'hff);
    avs_byteenable <= 4'hf;
    rd_check("ctrl byteenable", `OFS_CTRL, 32'h0);
    bus(1'b1, `OFS_CTRL, 32'hff);
    rd_check("ctrl mask", `OFS_CTRL, 32'hf3);
    bus(1'b1, `OFS_CTRL, 32'h0);
    bus(1'b1, `OFS_PIN_DIR, 32'h3);
    port_a_data <= 1'b1;
    settle();
    check("port pads", 32'h1, {30'h0, pad_b, pad_a});
    port_a_data <= 1'b0;
    port_b_data <= 1'b1;
    settle();
    check("port pads", 32'h2, {30'h0, pad_b, pad_a});
    port_b_data <= 1'b0;
    bus(1'b1, `OFS_CTRL, 32'hf0);
    bus(1'b1, `OFS_PIN_DIR, 32'h0);
    settle();
    check("oe_n", 32'h3, {30'h0, chan_b_pin_oe_n, chan_a_pin_oe_n});
    bus(1'b1, `OFS_PIN_DIR, 32'h3);
    run_case(8'hf0, 1'b0, 8'h05, 8'h05, 8'h05, 1, 1'b1, 1'b1);
    run_case(8'ha0, 1'b0, 8'h05, 8'h05, 8'h05, 1, 1'b0, 1'b0);
    run_case(8'h50, 1'b0, 8'h05, 8'h05, 8'h05, 1, 1'b1, 1'b1);
    bus(1'b1, `OFS_FLAGS, 32'h3);
    rd_check("flags cleared", `OFS_FLAGS, 32'h0);
    run_case(8'h52, 1'b0, 8'h05, 8'h03, 8'h03, 3, 1'b0, 1'b0);
    check("flags", 32'h3, {30'h0, chan_b_match_flag,
          chan_a_match_flag});
    rd_check("count wrap", `OFS_COUNT, 32'h0);
    run_case(8'hb3, 1'b0, 8'h02, 8'h02, 8'h02, 1, 1'b0, 1'b1);
    run_case(8'hb3, 1'b0, 8'h02, 8'h02, 8'hff, 1, 1'b1, 1'b0);
    run_case(8'hb3, 1'b0, 8'h02, 8'h02, 8'h02, 1, 1'b0, 1'b1);
    run_case(8'he3, 1'b0, 8'h02, 8'h02, 8'h02, 1, 1'b1, 1'b0);
    run_case(8'he3, 1'b0, 8'h02, 8'h02, 8'hff, 1, 1'b0, 1'b1);
    run_case(8'hb3, 1'b1, 8'h04, 8'h09, 8'h04, 1, 1'b1, 1'b0);
    run_case(8'he3, 1'b1, 8'h04, 8'h09, 8'h04, 1, 1'b0, 1'b1);
    run_case(8'h43, 1'b1, 8'h04, 8'h09, 8'h04, 1, 1'b1, 1'b0);
    run_case(8'h43, 1'b0, 8'h04, 8'h09, 8'h04, 1, 1'b0, 1'b0);
    // Output mode 01 is never set on channel B in the PWM cases.
    run_case(8'ha1, 1'b1, 8'h04, 8'h02, 8'h02, 1, 1'b1, 1'b0);
    run_case(8'ha1, 1'b1, 8'h04, 8'h02, 8'h03, 4, 1'b1, 1'b1);
    run_case(8'hf1, 1'b1, 8'h04, 8'h02, 8'h01, 7, 1'b0, 1'b1);
    run_case(8'hf1, 1'b1, 8'h04, 8'h02, 8'h02, 1, 1'b0, 1'b0);
    run_case(8'hb1, 1'b0, 8'h03, 8'h03, 8'h03, 1, 1'b1, 1'b0);
    run_case(8'hb1, 1'b0, 8'h03, 8'h03, 8'h00, 4, 1'b0, 1'b1);
    run_case(8'he1, 1'b0, 8'h03, 8'h03, 8'h03, 1, 1'b1, 1'b0);
    run_case(8'ha3, 1'b1, 8'h04, 8'h04, 8'h04, 1, 1'b1, 1'b1);
    tally_and_finish();
  end
endmodule
